// ### verilog/call_clear_branch_exec.sv
// Purpose: executes branch-on-null, two-word call, register zero and watchdog kick
// Assumes: fetch presents the current word and the word after it, same clock domain
// Notes:   one instruction cycle is four clocks, q1..q4, gated by the run bit
`default_nettype none
module call_clear_branch_exec
   import exec_pkg::*;
(
   input  wire logic                        clk,            // 100 MHz core clock
   input  wire logic                        rst_n,          // synchronous reset, low
   input  wire exec_pkg::apb_req_type       apb_req,        // apb request
   output exec_pkg::apb_rsp_type            apb_rsp,        // apb answer
   input  wire logic                        instr_valid,    // fetch has a word
   input  wire logic [15:0]                 instr_word,     // current word
   input  wire logic [15:0]                 instr_next,     // following word
   output logic                             instr_ready,    // word taken this clock
   input  wire logic [7:0]                  accumulator_in, // working register
   input  wire logic [exec_pkg::ADDR_W-1:0] index_base,     // indexed offset base
   output exec_pkg::dmem_req_type           dmem,           // data memory port
   output logic                             stack_push,     // return stack push pulse
   output logic [exec_pkg::PC_W-1:0]        return_stack_top, // top of return stack
   output logic [exec_pkg::PC_W-1:0]        pc_out,         // program counter
   output logic [1:0]                       phase_out       // quarter phase
);
   import exec_pkg::*;

   typedef enum logic {EXEC_ST, IDLE_ST} seq_type;

   phase_type              q_reg;
   seq_type                seq_reg;
   logic [15:0]            ir_reg;
   logic                   ir_valid_reg;
   logic [PC_W-1:0]        pc_reg;
   logic [7:0]             status_reg;
   logic [BANK_W-1:0]      bank_number_reg;
   logic [7:0]             accumulator_shadow;
   logic [7:0]             flags_shadow;
   logic [BANK_W-1:0]      bank_number_shadow;
   logic [PC_W-1:0]        stack_reg;
   logic                   push_reg;
   logic [1:0]             ctrl_reg;
   logic [WDT_W-1:0]       watchdog_counter;
   logic [WDT_W-1:0]       postscaler_reg;
   logic [31:0]            rdata_reg;
   logic                   rerr_reg;
   dmem_req_type           dmem_reg;
   logic [DATA_W-1:0]      lit_reg;

   // instruction classes, used by sequencer and checks alike
   function automatic logic is_branch(input logic [15:0] w);
      return w[15:8] == OPC_BRANCH_NULL;
   endfunction
   function automatic logic is_call(input logic [15:0] w);
      return w[15:9] == OPC_CALL_HI;
   endfunction
   function automatic logic is_zero(input logic [15:0] w);
      return w[15:9] == OPC_ZERO_HI;
   endfunction

   // target address of a register zero
   function automatic logic [ADDR_W-1:0] file_addr(input logic [7:0] f, input logic a,
                                                  input logic [BANK_W-1:0] bank,
                                                  input logic ext,
                                                  input logic [ADDR_W-1:0] base);
      if (a)
         return {bank, f};
      else if (ext && f <= INDEX_LIMIT)
         return base + {4'h0, f};
      else if (f < ACCESS_SPLIT)
         return {ACCESS_LOW, f};
      else
         return {ACCESS_HIGH, f};
   endfunction

   logic run;
   logic take_zero;
   logic ext_en;
   logic live;
   logic null_flag;
   logic [PC_W-1:0] branch_target;
   logic [PC_W-1:0] call_target;

   // a live instruction is one latched at q1 while not in an idle second cycle
   assign run           = ctrl_reg[CTRL_RUN_BIT];
   assign ext_en        = ctrl_reg[CTRL_EXT_BIT];
   assign live          = run && ir_valid_reg && seq_reg == EXEC_ST;
   assign null_flag     = status_reg[ST_NULL_BIT];
   assign branch_target = pc_reg + PC_STEP + {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
   assign call_target   = {instr_next[11:0], lit_reg, 1'b0};

   // quarter phase counter; holds while stopped so no phase repeats its action
   always_ff @(posedge clk) begin
      if (!rst_n)
         q_reg <= Q1_PH;
      else if (run)
         q_reg <= phase_type'(q_reg + 2'h1);
   end

   // fetch handshake: a word is only accepted at q1 of a normal cycle
   assign instr_ready = run && q_reg == Q1_PH && seq_reg == EXEC_ST;
   assign take_zero   = instr_ready && instr_valid && is_zero(instr_word);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ir_reg       <= 16'h0000;
         ir_valid_reg <= 1'b0;
      end else if (run && q_reg == Q1_PH) begin
         ir_reg       <= instr_word;
         ir_valid_reg <= instr_ready && instr_valid;
      end
   end

   // literal read at q2, low target bits for call; the branch offset is taken straight from ir_reg
   always_ff @(posedge clk) begin
      if (!rst_n)
         lit_reg <= 8'h00;
      else if (live && q_reg == Q2_PH)
         lit_reg <= ir_reg[7:0];
   end

   // sequencer: taken branch and call insert one idle cycle
   always_ff @(posedge clk) begin
      if (!rst_n)
         seq_reg <= EXEC_ST;
      else if (run && q_reg == Q4_PH) begin
         case (seq_reg)
            EXEC_ST: begin
               if (live && (is_call(ir_reg) || (is_branch(ir_reg) && null_flag)))
                  seq_reg <= IDLE_ST;
            end
            IDLE_ST: seq_reg <= EXEC_ST;
            default: seq_reg <= EXEC_ST;
         endcase
      end
   end

   // program counter, written only in q4 of a live instruction
   always_ff @(posedge clk) begin
      if (!rst_n)
         pc_reg <= '0;
      else if (live && q_reg == Q4_PH) begin
         if (is_call(ir_reg))
            pc_reg <= call_target;
         else if (is_branch(ir_reg) && null_flag)
            pc_reg <= branch_target;
         else
            pc_reg <= pc_reg + PC_STEP;
      end
   end

   // return stack top and push pulse in q3 of a call
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stack_reg <= '0;
         push_reg  <= 1'b0;
      end else begin
         push_reg <= live && q_reg == Q3_PH && is_call(ir_reg);
         if (live && q_reg == Q3_PH && is_call(ir_reg))
            stack_reg <= pc_reg + CALL_STEP;
      end
   end

   // shadow copies only move on a call with the save bit set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         accumulator_shadow <= 8'h00;
         flags_shadow       <= 8'h00;
         bank_number_shadow <= BANK_RESET;
      end else if (live && q_reg == Q3_PH && is_call(ir_reg) && ir_reg[8]) begin
         accumulator_shadow <= accumulator_in;
         flags_shadow       <= status_reg;
         bank_number_shadow <= bank_number_reg;
      end
   end

   // data memory port: address taken from the incoming word so it already stands in q2
   always_ff @(posedge clk) begin
      if (!rst_n)
         dmem_reg <= '0;
      else begin
         dmem_reg.rd <= take_zero;
         dmem_reg.we <= live && q_reg == Q3_PH && is_zero(ir_reg);
         if (take_zero) begin
            dmem_reg.addr <= file_addr(instr_word[7:0], instr_word[8], bank_number_reg,
                                       ext_en, index_base);
            dmem_reg.data <= ZERO_DATA;
         end
      end
   end

   // status: software writes first, hardware sets override in the same clock
   always_ff @(posedge clk) begin
      if (!rst_n)
         status_reg <= STATUS_RESET;
      else begin
         if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFS_STATUS)
            status_reg <= apb_req.pwdata[7:0];
         if (live && q_reg == Q3_PH && is_zero(ir_reg))
            status_reg[ST_NULL_BIT] <= 1'b1;
         if (live && q_reg == Q3_PH && ir_reg == OPC_KICK) begin
            status_reg[ST_TO_BIT] <= 1'b1;
            status_reg[ST_PD_BIT] <= 1'b1;
         end
      end
   end

   // watchdog counter with postscaler on wrap; kick clears both
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         watchdog_counter <= WDT_CLEAR;
         postscaler_reg   <= WDT_CLEAR;
      end else if (live && q_reg == Q3_PH && ir_reg == OPC_KICK) begin
         watchdog_counter <= WDT_CLEAR;
         postscaler_reg   <= WDT_CLEAR;
      end else if (run) begin
         watchdog_counter <= watchdog_counter + 8'h01;
         if (&watchdog_counter)
            postscaler_reg <= postscaler_reg + 8'h01;
      end
   end

   // apb control and bank registers, written in the access phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg        <= CTRL_RESET;
         bank_number_reg <= BANK_RESET;
      end else if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
         if (apb_req.paddr == OFS_CTRL)
            ctrl_reg <= apb_req.pwdata[1:0];
         if (apb_req.paddr == OFS_BANK)
            bank_number_reg <= apb_req.pwdata[BANK_W-1:0];
      end
   end

   // read data is captured in the setup phase so it comes from a flip-flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_reg <= 32'h00000000;
         rerr_reg  <= 1'b0;
      end else if (apb_req.psel && !apb_req.penable) begin
         rerr_reg  <= 1'b0;
         case (apb_req.paddr)
            OFS_CTRL:   rdata_reg <= {30'h0, ctrl_reg};
            OFS_STATUS: rdata_reg <= {24'h0, status_reg};
            OFS_BANK:   rdata_reg <= {28'h0, bank_number_reg};
            OFS_PC:     rdata_reg <= {11'h0, pc_reg};
            OFS_STACK:  rdata_reg <= {11'h0, stack_reg};
            OFS_SHADOW: rdata_reg <= {4'h0, bank_number_shadow, flags_shadow,
                                      8'h00, accumulator_shadow};
            OFS_WDT:    rdata_reg <= {16'h0, postscaler_reg, watchdog_counter};
            default: begin
               rdata_reg <= 32'h00000000;
               rerr_reg  <= 1'b1;
            end
         endcase
      end
   end

   // zero wait states: the slave answers in the first access cycle
   assign apb_rsp.prdata  = rdata_reg;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = rerr_reg && apb_req.psel && apb_req.penable;

   assign dmem             = dmem_reg;
   assign stack_push       = push_reg;
   assign return_stack_top = stack_reg;
   assign pc_out           = pc_reg;
   assign phase_out        = q_reg;

   // checks
   property p_branch_taken;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q4_PH && is_branch(ir_reg) && null_flag)
         |=> (pc_reg == $past(branch_target)) && seq_reg == IDLE_ST;
   endproperty
   a_branch_taken: assert property (p_branch_taken) else $error("branch jump wrong");

   property p_branch_not_taken;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q4_PH && is_branch(ir_reg) && !null_flag)
         |=> pc_reg == $past(pc_reg) + PC_STEP && seq_reg == EXEC_ST && !dmem_reg.we;
   endproperty
   a_branch_not_taken: assert property (p_branch_not_taken) else $error("skip wrong");

   property p_call_push;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q3_PH && is_call(ir_reg))
         |=> stack_push && return_stack_top == $past(pc_reg) + CALL_STEP;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push wrong");

   property p_shadow_save;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q3_PH && is_call(ir_reg) && ir_reg[8])
         |=> accumulator_shadow == $past(accumulator_in) && flags_shadow == $past(status_reg);
   endproperty
   a_shadow_save: assert property (p_shadow_save) else $error("shadow not saved");

   property p_shadow_keep;
      @(posedge clk) disable iff (!rst_n)
      !(live && q_reg == Q3_PH && is_call(ir_reg) && ir_reg[8])
         |=> $stable(accumulator_shadow) && $stable(bank_number_shadow)
             && $stable(flags_shadow);
   endproperty
   a_shadow_keep: assert property (p_shadow_keep) else $error("shadow changed");

   property p_call_target;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q4_PH && is_call(ir_reg))
         |=> pc_reg == {$past(instr_next[11:0]), $past(ir_reg[7:0]), 1'b0}
             ##4 seq_reg == EXEC_ST;
   endproperty
   a_call_target: assert property (p_call_target) else $error("call target wrong");

   property p_zero_write;
      @(posedge clk) disable iff (!rst_n)
      dmem_reg.we |-> dmem_reg.data == ZERO_DATA && status_reg[ST_NULL_BIT] == 1'b1 ##0
         $past(q_reg) == Q3_PH;
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write wrong");

   property p_bank_select;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q3_PH && is_zero(ir_reg) && ir_reg[8])
         |=> dmem_reg.we && dmem_reg.addr == {$past(bank_number_reg), $past(ir_reg[7:0])};
   endproperty
   a_bank_select: assert property (p_bank_select) else $error("bank addr wrong");

   property p_kick;
      @(posedge clk) disable iff (!rst_n)
      (live && q_reg == Q3_PH && ir_reg == OPC_KICK)
         |=> watchdog_counter == WDT_CLEAR && postscaler_reg == WDT_CLEAR
             && status_reg[ST_TO_BIT] && status_reg[ST_PD_BIT];
   endproperty
   a_kick: assert property (p_kick) else $error("watchdog kick wrong");

   c_taken:  cover property (@(posedge clk) live && is_branch(ir_reg) && null_flag);
   c_call_s: cover property (@(posedge clk) stack_push && ir_reg[8]);
   c_zero:   cover property (@(posedge clk) dmem_reg.we);
   c_kick:   cover property (@(posedge clk) live && q_reg == Q3_PH && ir_reg == OPC_KICK);
endmodule
`default_nettype wire

// ### verilog/exec_pkg.sv
// Purpose: shared constants and carriers for the branch, call, zero and kick executor
// Assumes: 100 MHz clk, four clocks per instruction cycle (one per quarter phase)
// Notes:   apb registers are word aligned, byte address = offset
`default_nettype none
package exec_pkg;
   localparam int PC_W            = 21;
   localparam int ADDR_W          = 12;
   localparam int DATA_W          = 8;
   localparam int BANK_W          = 4;
   // opcode patterns
   localparam logic [7:0]  OPC_BRANCH_NULL = 8'hE0;
   localparam logic [6:0]  OPC_CALL_HI     = 7'h76;
   localparam logic [3:0]  OPC_CALL_PREFIX = 4'hF;
   localparam logic [6:0]  OPC_ZERO_HI     = 7'h35;
   localparam logic [15:0] OPC_KICK        = 16'h0004;
   // program counter steps
   localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
   localparam logic [PC_W-1:0] CALL_STEP = 21'h000004;
   // status field positions and reset
   localparam int ST_NULL_BIT = 2;
   localparam int ST_PD_BIT   = 3;
   localparam int ST_TO_BIT   = 4;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   // data memory addressing
   localparam logic [7:0]        INDEX_LIMIT  = 8'h5F;
   localparam logic [7:0]        ACCESS_SPLIT = 8'h80;
   localparam logic [BANK_W-1:0] ACCESS_LOW   = 4'h0;
   localparam logic [BANK_W-1:0] ACCESS_HIGH  = 4'hF;
   localparam logic [DATA_W-1:0] ZERO_DATA    = 8'h00;
   // watchdog
   localparam int WDT_W = 8;
   localparam logic [WDT_W-1:0] WDT_CLEAR = 8'h00;
   // apb offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_BANK   = 8'h08;
   localparam logic [7:0] OFS_PC     = 8'h0C;
   localparam logic [7:0] OFS_STACK  = 8'h10;
   localparam logic [7:0] OFS_SHADOW = 8'h14;
   localparam logic [7:0] OFS_WDT    = 8'h18;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_EXT_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;

   typedef enum logic [1:0] {Q1_PH, Q2_PH, Q3_PH, Q4_PH} phase_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic              rd;
      logic              we;
   } dmem_req_type;
endpackage
`default_nettype wire

// ### verification/tb.sv
// Purpose: self-checking bench for the branch, call, zero and kick executor
// Assumes: zero-wait apb slave, four clocks per instruction cycle, run bit gates execution
// Notes:   drivers note expectations in queues, a negedge monitor pops and compares them
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import exec_pkg::*;

   logic              clk            = 1'b0;
   logic              rst_n          = 1'b0;
   apb_req_type       apb_req        = '0;
   apb_rsp_type       apb_rsp;
   logic              instr_valid    = 1'b0;
   logic [15:0]       instr_word     = 16'h0000;
   logic [15:0]       instr_next     = 16'h0000;
   logic              instr_ready;
   logic [7:0]        accumulator_in = 8'h00;
   logic [ADDR_W-1:0] index_base     = 12'h000;
   dmem_req_type      dmem;
   logic              stack_push;
   logic [PC_W-1:0]   return_stack_top;
   logic [PC_W-1:0]   pc_out;
   logic [1:0]        phase_out;
   int                fails          = 0;
   int                n_checks       = 0;
   logic [31:0]       q_rd[$];
   logic [31:0]       q_mask[$];
   logic [ADDR_W-1:0] q_wr[$];
   logic [PC_W-1:0]   q_push[$];
   logic [PC_W-1:0]   exp_pc         = '0;
   logic [31:0]       m;
   logic [31:0]       shadow;
   logic [19:0]       k;
   logic [ADDR_W-1:0] ea;
   logic [ADDR_W-1:0] ib;
   logic [7:0]        st;
   logic [7:0]        f;
   logic [7:0]        n;
   logic [7:0]        acc;
   logic [3:0]        bank;
   logic              a;
   logic              ext;

   call_clear_branch_exec DUT (
      .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .instr_valid(instr_valid), .instr_word(instr_word), .instr_next(instr_next),
      .instr_ready(instr_ready), .accumulator_in(accumulator_in), .index_base(index_base),
      .dmem(dmem), .stack_push(stack_push), .return_stack_top(return_stack_top),
      .pc_out(pc_out), .phase_out(phase_out));

   always #5 clk = ~clk;

   // shared comparison, every kind of result funnels through here
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s at %0t: exp %h got %h", what, $time, e, g);
      end
   endtask
   task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
      cmp("read", e, g);
   endtask
   task automatic chk_wr(input logic [19:0] e, input logic [19:0] g);
      cmp("dmem", {12'h000, e}, {12'h000, g});
   endtask
   task automatic chk_push(input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
      cmp("push", {11'h000, e}, {11'h000, g});
   endtask
   task automatic chk_ph(input logic [1:0] e, input logic [1:0] g);
      cmp("phase", {30'h0, e}, {30'h0, g});
   endtask
   task automatic chk_err(input logic e, input logic g);
      cmp("slverr", {31'h0, e}, {31'h0, g});
   endtask

   // apb master: hold the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int g;
      g = 0;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         g++;
      end while (apb_rsp.pready !== 1'b1 && g < 50);
      if (g >= 50)
         fails++;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk);
      q_rd.push_back(e & mk);
      q_mask.push_back(mk);
      apb(1'b0, ad, 32'h0000_0000);
   endtask

   // offer one instruction, wait for q1 acceptance, then let two cycles pass
   task automatic exec(input logic [15:0] w, input logic [15:0] nx);
      int g;
      g = 0;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      instr_next <= nx;
      do begin
         @(negedge clk);
         g++;
      end while (instr_ready !== 1'b1 && g < 20);
      if (g >= 20)
         fails++;
      @(posedge clk);
      instr_valid <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   // monitor samples settled outputs at the falling edge, so no race with drivers
   always @(negedge clk) begin
      if (rst_n) begin
         if (apb_req.psel && apb_req.penable && apb_rsp.pready) begin
            chk_err(apb_req.paddr > OFS_WDT || apb_req.paddr[1:0] != 2'h0, apb_rsp.pslverr);
            if (!apb_req.pwrite) begin
               m = q_mask.pop_front();
               chk_rd(q_rd.pop_front(), apb_rsp.prdata & m);
            end
         end
         if (dmem.rd === 1'b1)
            chk_ph(2'h1, phase_out);
         if (dmem.we === 1'b1) begin
            chk_ph(2'h3, phase_out);
            chk_wr((q_wr.size() > 0) ? {q_wr.pop_front(), ZERO_DATA} : 20'hFFFFF,
                   {dmem.addr, dmem.data});
         end
         if (stack_push === 1'b1)
            chk_push((q_push.size() > 0) ? q_push.pop_front() : '1, return_stack_top);
      end
   end

   task automatic stop_test();
      if (q_rd.size() + q_wr.size() + q_push.size() > 0)
         fails++;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // cut a hang short: the whole run needs under a thousand clocks
   initial begin
      #100000;
      fails++;
      stop_test();
   end

   initial begin
      void'($urandom(98840));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_STATUS, {24'h0, STATUS_RESET}, 32'h0000_00FF);
      rd(OFS_CTRL, 32'h0, 32'h0000_0003);
      rd(8'h1C, 32'h0, 32'hFFFF_FFFF);
      $display("test reset done");
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      // branch on null, not taken first, then taken with a random signed offset
      for (int z = 0; z < 2; z++) begin
         n = 8'($urandom);
         apb(1'b1, OFS_STATUS, z ? 32'h0000_0004 : 32'h0000_0000);
         exec({OPC_BRANCH_NULL, n}, 16'h0000);
         exp_pc = z ? exp_pc + PC_STEP + {{12{n[7]}}, n, 1'b0} : exp_pc + PC_STEP;
         rd(OFS_PC, {11'h0, exp_pc}, 32'hFFFF_FFFF);
      end
      $display("test branch done");
      // call with save, then without: shadows must keep the first copy
      for (int s = 1; s >= 0; s--) begin
         k = 20'($urandom);
         bank = 4'($urandom);
         acc = 8'($urandom);
         st = 8'($urandom) & 8'h1C;
         accumulator_in <= acc;
         apb(1'b1, OFS_BANK, {28'h0, bank});
         apb(1'b1, OFS_STATUS, {24'h0, st});
         q_push.push_back(exp_pc + CALL_STEP);
         rd(OFS_PC, {11'h0, exp_pc}, 32'hFFFF_FFFF);
         exec({OPC_CALL_HI, s[0], k[7:0]}, {OPC_CALL_PREFIX, k[19:8]});
         rd(OFS_STACK, {11'h0, exp_pc + CALL_STEP}, 32'hFFFF_FFFF);
         exp_pc = {k, 1'b0};
         rd(OFS_PC, {11'h0, exp_pc}, 32'hFFFF_FFFF);
         if (s == 1)
            shadow = {4'h0, bank, st, 8'h00, acc};
         rd(OFS_SHADOW, shadow, 32'h0F1C_00FF);
      end
      $display("test call done");
      // register zero over both access modes, extended set and the 5Fh boundary
      for (int i = 0; i < 8; i++) begin
         f = (i == 2) ? 8'h5F : (i == 6) ? 8'h60 : 8'($urandom);
         a = i[0];
         ext = i[1];
         bank = 4'($urandom);
         ib = 12'($urandom);
         index_base <= ib;
         apb(1'b1, OFS_CTRL, {30'h0, ext, 1'b1});
         apb(1'b1, OFS_BANK, {28'h0, bank});
         apb(1'b1, OFS_STATUS, 32'h0000_0000);
         if (a)
            ea = {bank, f};
         else if (ext && f <= INDEX_LIMIT)
            ea = ib + {4'h0, f};
         else
            ea = (f < ACCESS_SPLIT) ? {ACCESS_LOW, f} : {ACCESS_HIGH, f};
         q_wr.push_back(ea);
         exec({OPC_ZERO_HI, a, f}, 16'h0000);
         exp_pc = exp_pc + PC_STEP;
         rd(OFS_STATUS, 32'h0000_0004, 32'h0000_001C);
      end
      rd(OFS_PC, {11'h0, exp_pc}, 32'hFFFF_FFFF);
      $display("test zero done");
      // let the postscaler move before the kick so its clearing shows
      apb(1'b1, OFS_STATUS, 32'h0000_0000);
      repeat (300) @(posedge clk);
      exec(OPC_KICK, 16'h0000);
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      exp_pc = exp_pc + PC_STEP;
      rd(OFS_WDT, 32'h0, 32'h0000_FF00);
      rd(OFS_STATUS, 32'h0000_0018, 32'h0000_001C);
      rd(OFS_PC, {11'h0, exp_pc}, 32'hFFFF_FFFF);
      $display("test kick done");
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule
`default_nettype wire
